// [rtl/adcctl_pkg.sv]
package adcctl_pkg;
  // bus and field widths
  localparam int unsigned ADDR_W        = 8;
  localparam int unsigned DATA_W        = 32;
  localparam int unsigned RES_W         = 12;
  localparam int unsigned SEL_W         = 5;
  localparam int unsigned GAIN_W        = 5;
  localparam int unsigned DIV_W         = 6;
  localparam int unsigned ACQ_W         = 6;
  localparam int unsigned CNT_W         = 8;

  // register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS   = 8'h00;
  localparam logic [ADDR_W-1:0] CPOS_OFS   = 8'h04;
  localparam logic [ADDR_W-1:0] CNEG_OFS   = 8'h08;
  localparam logic [ADDR_W-1:0] STAT_OFS   = 8'h0c;
  localparam logic [ADDR_W-1:0] RSLT_OFS   = 8'h10;
  localparam logic [ADDR_W-1:0] SRST_OFS   = 8'h14;
  localparam logic [ADDR_W-1:0] GAIN_OFS   = 8'h18;

  // control, status and result register fields
  localparam int unsigned CTL_EN_BIT     = 0;
  localparam int unsigned CTL_START_BIT  = 1;
  localparam int unsigned CTL_CONT_BIT   = 2;
  localparam int unsigned CTL_MODE_LO    = 3;
  localparam int unsigned CTL_MODE_HI    = 4;
  localparam int unsigned CTL_EXT_BIT    = 5;
  localparam int unsigned CTL_DIV_LO     = 8;
  localparam int unsigned CTL_DIV_HI     = 13;
  localparam int unsigned CTL_BYP_N_BIT  = 14;
  localparam int unsigned CTL_BYP_P_BIT  = 15;
  localparam int unsigned CTL_ACQ_LO     = 16;
  localparam int unsigned CTL_ACQ_HI     = 21;
  localparam int unsigned STA_READY_BIT  = 0;
  localparam int unsigned RES_LO         = 16;
  localparam int unsigned RES_HI         = 27;

  // conversion modes
  localparam logic [1:0] MODE_SINGLE    = 2'h0;
  localparam logic [1:0] MODE_DIFF      = 2'h1;
  localparam logic [1:0] MODE_PSEUDO    = 2'h2;

  // positive channel codes
  localparam logic [SEL_W-1:0] CH_EXT_LAST   = 5'h06;
  localparam logic [SEL_W-1:0] CH_PHOTO0     = 5'h07;
  localparam logic [SEL_W-1:0] CH_PHOTO1     = 5'h08;
  localparam logic [SEL_W-1:0] CH_SUPPLY0    = 5'h09;
  localparam logic [SEL_W-1:0] CH_IDAC0      = 5'h0c;
  localparam logic [SEL_W-1:0] CH_TEMP       = 5'h11;
  localparam logic [SEL_W-1:0] CH_VREF       = 5'h12;
  localparam logic [SEL_W-1:0] CH_AGND       = 5'h13;
  localparam logic [SEL_W-1:0] CH_POS_MAX    = 5'h13;
  // negative channel codes
  localparam logic [SEL_W-1:0] CHN_PHOTO0    = 5'h07;
  localparam logic [SEL_W-1:0] CHN_PHOTO1    = 5'h08;
  localparam logic [SEL_W-1:0] CHN_MAX       = 5'h09;

  // reset values and timing counts
  localparam logic [DIV_W-1:0]  DIV_RST      = 6'h02;
  localparam logic [ACQ_W-1:0]  ACQ_RST      = 6'h08;
  localparam logic [DIV_W-1:0]  DIV_TEMP     = 6'h20;
  localparam logic [ACQ_W-1:0]  ACQ_TEMP     = 6'h10;
  localparam logic [CNT_W-1:0]  TRIAL_CLKS   = 8'h13;
  localparam logic [1:0]        MODE_RST     = MODE_SINGLE;
  localparam logic [GAIN_W-1:0] GAIN_RST     = 5'h00;
  localparam logic [SEL_W-1:0]  SEL_RST      = 5'h00;
endpackage

// [rtl/adcctl_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none
module adcctl_sequencer
  import adcctl_pkg::*;
(
  input  wire logic             MCLK_I,
  input  wire logic             RST_N_I,
  input  wire logic             abort_i,
  input  wire logic             start_i,
  input  wire logic [DIV_W-1:0] div_i,
  input  wire logic [ACQ_W-1:0] acq_i,
  output logic                  busy_o,
  output logic                  sample_o,
  output logic                  conv_clk_o,
  output logic                  done_o
);
  typedef enum logic [1:0] {ADCSQ_IDLE, ADCSQ_ACQ, ADCSQ_TRIAL} adcsq_state_t;

  adcsq_state_t     state_reg;
  logic [DIV_W-1:0] div_reg;
  logic [DIV_W-1:0] pre_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] acq_last;
  logic             tick;

  // one converter clock every div system clocks; zero acts as one
  assign tick     = (pre_reg >= div_reg - 6'h01) || (div_reg == '0);
  assign acq_last = {{(CNT_W-ACQ_W){1'b0}}, acq_i} - 8'h01;
  assign busy_o   = (state_reg != ADCSQ_IDLE);
  assign sample_o = (state_reg == ADCSQ_ACQ);

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pre_reg    <= '0;
      conv_clk_o <= 1'b0;
    end else if (state_reg == ADCSQ_IDLE || abort_i || tick) begin
      pre_reg    <= '0;
      conv_clk_o <= (state_reg != ADCSQ_IDLE) && !abort_i;
    end else begin
      pre_reg    <= pre_reg + 6'h01;
      conv_clk_o <= 1'b0;
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_reg <= ADCSQ_IDLE;
      div_reg   <= DIV_RST;
      cnt_reg   <= '0;
      done_o    <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (abort_i) begin
        state_reg <= ADCSQ_IDLE;
      end else begin
        case (state_reg)
          ADCSQ_IDLE: begin
            if (start_i) begin
              div_reg   <= div_i;
              cnt_reg   <= (acq_i == '0) ? '0 : acq_last;
              state_reg <= ADCSQ_ACQ;
            end
          end
          ADCSQ_ACQ: begin
            if (tick) begin
              if (cnt_reg == '0) begin
                cnt_reg   <= TRIAL_CLKS - 8'h01;
                state_reg <= ADCSQ_TRIAL;
              end else begin
                cnt_reg <= cnt_reg - 8'h01;
              end
            end
          end
          ADCSQ_TRIAL: begin
            if (tick) begin
              if (cnt_reg == '0) begin
                done_o    <= 1'b1;
                state_reg <= ADCSQ_IDLE;
              end else begin
                cnt_reg <= cnt_reg - 8'h01;
              end
            end
          end
          default: state_reg <= ADCSQ_IDLE;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// [rtl/adcctl_top.sv]
// Behaviour
// - differential mode yields twos complement codes, step twice reference over 4096.
// - differential result is sign plus 11 bits, readable as signed integer.
// - single-ended and pseudo differential yield straight binary, step reference over 4096.
// - result sits in bits 27..16, four bits above hold sign copies.
// - control bit 15 bypasses positive buffer, bit 14 negative, independently.
// - control bits 4..3 choose single-ended, pseudo or fully differential mode.
// - amplifier gain code gives 32 linear steps from gain 1 to 5.
// - amplifier stays in path whenever a photo input pair is selected.
// - buffer and mode settings live apart from channel selection.
// - positive select covers pins, supplies, current outputs, diode, reference, ground.
// - control fields set converter clock divider and acquisition clock count.
// - reset timing is 8 acquisition clocks, divider 2, plus 19 clocks.
// - temperature channel forces 16 acquisition clocks and divider 32.
// - user timing applies again once a positive channel other than temperature is selected.
// - ready flag bit 0 set at conversion end, cleared by reading result.
// - conversion-active output high during conversion, low once finished.
// - trigger still high at conversion end starts another conversion.
// - writing the soft reset register returns all registers to defaults.
`timescale 1ns/1ps
`default_nettype none
module adcctl_top
  import adcctl_pkg::*;
(
  input  wire logic                           MCLK_I,
  input  wire logic                           RST_N_I,
  input  wire logic                           PSEL_I,
  input  wire logic                           PENABLE_I,
  input  wire logic                           PWRITE_I,
  input  wire logic [adcctl_pkg::ADDR_W-1:0]  PADDR_I,
  input  wire logic [adcctl_pkg::DATA_W-1:0]  PWDATA_I,
  output logic      [adcctl_pkg::DATA_W-1:0]  PRDATA_O,
  output logic                                PREADY_O,
  output logic                                PSLVERR_O,
  input  wire logic                           CONV_TRIGGER_I,
  input  wire logic [adcctl_pkg::RES_W-1:0]   CORE_DATA_I,
  output logic      [adcctl_pkg::SEL_W-1:0]   POSITIVE_CHANNEL_SELECT_O,
  output logic      [adcctl_pkg::SEL_W-1:0]   NEGATIVE_CHANNEL_SELECT_O,
  output logic      [1:0]                     CONV_MODE_O,
  output logic                                BYPASS_POS_BUFFER_O,
  output logic                                BYPASS_NEG_BUFFER_O,
  output logic      [adcctl_pkg::GAIN_W-1:0]  AMPLIFIER_GAIN_CODE_O,
  output logic                                AMPLIFIER_IN_PATH_O,
  output logic                                SAMPLE_O,
  output logic                                CONV_CLK_O,
  output logic                                CONVERSION_ACTIVE_OUTPUT_O,
  output logic                                RESULT_READY_FLAG_O
);
  import adcctl_pkg::*;

  logic             en_reg;
  logic             cont_reg;
  logic             ext_reg;
  logic [1:0]       mode_reg;
  logic [DIV_W-1:0] div_reg;
  logic [ACQ_W-1:0] acq_reg;
  logic             byp_p_reg;
  logic             byp_n_reg;
  logic [SEL_W-1:0] pos_reg;
  logic [SEL_W-1:0] neg_reg;
  logic [GAIN_W-1:0] gain_reg;
  logic             ready_reg;
  logic             in_path_reg;
  logic [DATA_W-1:0] result_reg;
  logic [1:0]       conv_mode_reg;
  logic             sw_start_reg;
  logic [2:0]       trig_sync_reg;
  logic             trig_reg;
  logic             trig_prev_reg;
  logic             soft_reset;
  logic             wr_access;
  logic             rd_setup;
  logic             rd_result;
  logic             mapped;
  logic             busy;
  logic             done;
  logic             start;
  logic             temp_sel;
  logic [DIV_W-1:0] eff_div;
  logic [ACQ_W-1:0] eff_acq;
  logic [DATA_W-1:0] rd_data;

  // decode helper used by both read and write paths
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    logic hit;
    hit = 1'b0;
    if (a == CTRL_OFS) begin
      hit = 1'b1;
    end else if (a == CPOS_OFS) begin
      hit = 1'b1;
    end else if (a == CNEG_OFS) begin
      hit = 1'b1;
    end else if (a == STAT_OFS) begin
      hit = 1'b1;
    end else if (a == RSLT_OFS) begin
      hit = 1'b1;
    end else if (a == SRST_OFS) begin
      hit = 1'b1;
    end else if (a == GAIN_OFS) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  // photo pair decode for the amplifier path flag
  function automatic logic is_photo(input logic [SEL_W-1:0] p,
                                    input logic [SEL_W-1:0] n);
    logic hit;
    hit = (p == CH_PHOTO0) || (p == CH_PHOTO1);
    if (n == CHN_PHOTO0 || n == CHN_PHOTO1) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  // conversion code to result word
  function automatic logic [DATA_W-1:0] format_result(input logic [1:0]       m,
                                                      input logic [RES_W-1:0] raw);
    logic [RES_W-1:0] code;
    logic             sign;
    int               b;
    code          = raw;
    sign          = 1'b0;
    format_result = '0;
    if (m == MODE_DIFF) begin
      code = {~raw[RES_W-1], raw[RES_W-2:0]};
      sign = code[RES_W-1];
    end
    format_result[RES_HI:RES_LO] = code;
    for (b = RES_HI + 1; b < DATA_W; b++) begin
      format_result[b] = sign;
    end
  endfunction

  assign mapped     = is_mapped(PADDR_I);
  assign wr_access  = PSEL_I && PENABLE_I && PWRITE_I && mapped;
  assign rd_setup   = PSEL_I && !PENABLE_I && !PWRITE_I;
  assign rd_result  = PSEL_I && PENABLE_I && !PWRITE_I && (PADDR_I == RSLT_OFS);
  assign soft_reset = wr_access && (PADDR_I == SRST_OFS);
  assign PREADY_O   = 1'b1;
  assign PSLVERR_O  = PSEL_I && PENABLE_I && !mapped;

  // trigger pin synchroniser, a change counts when stages two and three agree
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      trig_sync_reg <= 3'h0;
      trig_reg      <= 1'b0;
      trig_prev_reg <= 1'b0;
    end else begin
      trig_sync_reg <= {trig_sync_reg[1:0], CONV_TRIGGER_I};
      if (trig_sync_reg[1] == trig_sync_reg[2]) begin
        trig_reg <= trig_sync_reg[2];
      end
      trig_prev_reg <= trig_reg;
    end
  end

  // control register, buffer bypass and mode kept apart from channel selects
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      en_reg    <= 1'b0;
      cont_reg  <= 1'b0;
      ext_reg   <= 1'b0;
      mode_reg  <= MODE_RST;
      div_reg   <= DIV_RST;
      acq_reg   <= ACQ_RST;
      byp_p_reg <= 1'b0;
      byp_n_reg <= 1'b0;
    end else if (soft_reset) begin
      en_reg    <= 1'b0;
      cont_reg  <= 1'b0;
      ext_reg   <= 1'b0;
      mode_reg  <= MODE_RST;
      div_reg   <= DIV_RST;
      acq_reg   <= ACQ_RST;
      byp_p_reg <= 1'b0;
      byp_n_reg <= 1'b0;
    end else if (wr_access && PADDR_I == CTRL_OFS) begin
      en_reg    <= PWDATA_I[CTL_EN_BIT];
      cont_reg  <= PWDATA_I[CTL_CONT_BIT];
      ext_reg   <= PWDATA_I[CTL_EXT_BIT];
      mode_reg  <= PWDATA_I[CTL_MODE_HI:CTL_MODE_LO];
      div_reg   <= PWDATA_I[CTL_DIV_HI:CTL_DIV_LO];
      acq_reg   <= PWDATA_I[CTL_ACQ_HI:CTL_ACQ_LO];
      byp_p_reg <= PWDATA_I[CTL_BYP_P_BIT];
      byp_n_reg <= PWDATA_I[CTL_BYP_N_BIT];
    end
  end

  // software start is a one-cycle strobe taken from the control write
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sw_start_reg <= 1'b0;
    end else begin
      sw_start_reg <= wr_access && (PADDR_I == CTRL_OFS) && PWDATA_I[CTL_START_BIT]
                      && PWDATA_I[CTL_EN_BIT];
    end
  end

  // channel selects and amplifier gain, out-of-range codes ignored
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pos_reg     <= SEL_RST;
      neg_reg     <= SEL_RST;
      gain_reg    <= GAIN_RST;
      in_path_reg <= 1'b0;
    end else if (soft_reset) begin
      pos_reg     <= SEL_RST;
      neg_reg     <= SEL_RST;
      gain_reg    <= GAIN_RST;
      in_path_reg <= 1'b0;
    end else if (wr_access) begin
      if (PADDR_I == CPOS_OFS && PWDATA_I[SEL_W-1:0] <= CH_POS_MAX) begin
        pos_reg     <= PWDATA_I[SEL_W-1:0];
        in_path_reg <= is_photo(PWDATA_I[SEL_W-1:0], neg_reg);
      end else if (PADDR_I == CNEG_OFS && PWDATA_I[SEL_W-1:0] <= CHN_MAX) begin
        neg_reg     <= PWDATA_I[SEL_W-1:0];
        in_path_reg <= is_photo(pos_reg, PWDATA_I[SEL_W-1:0]);
      end else if (PADDR_I == GAIN_OFS) begin
        gain_reg <= PWDATA_I[GAIN_W-1:0];
      end
    end
  end

  // temperature channel overrides timing only for its own conversion
  assign temp_sel = (pos_reg == CH_TEMP);
  assign eff_div  = temp_sel ? DIV_TEMP : div_reg;
  assign eff_acq  = temp_sel ? ACQ_TEMP : acq_reg;

  // start sources: software, continuous, trigger edge or trigger still held
  always_comb begin
    start = 1'b0;
    if (en_reg && !busy && !done && !soft_reset) begin
      if (sw_start_reg || cont_reg) begin
        start = 1'b1;
      end else if (ext_reg && trig_reg && !trig_prev_reg) begin
        start = 1'b1;
      end
    end
  end
  logic restart_reg;
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      restart_reg <= 1'b0;
    end else begin
      restart_reg <= done && en_reg && ext_reg && trig_reg && !soft_reset;
    end
  end

  adcctl_sequencer u_seq (
    .MCLK_I     (MCLK_I),
    .RST_N_I    (RST_N_I),
    .abort_i    (soft_reset),
    .start_i    (start || restart_reg),
    .div_i      (eff_div),
    .acq_i      (eff_acq),
    .busy_o     (busy),
    .sample_o   (SAMPLE_O),
    .conv_clk_o (CONV_CLK_O),
    .done_o     (done)
  );

  // mode latched at start so a late mode write cannot recode a result
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      conv_mode_reg <= MODE_RST;
    end else if (soft_reset) begin
      conv_mode_reg <= MODE_RST;
    end else if ((start || restart_reg) && !busy) begin
      conv_mode_reg <= mode_reg;
    end
  end

  // result capture and ready flag; a new result wins over a read clear
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      result_reg <= '0;
    end else if (soft_reset) begin
      result_reg <= '0;
    end else if (done) begin
      result_reg <= format_result(conv_mode_reg, CORE_DATA_I);
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ready_reg <= 1'b0;
    end else if (soft_reset) begin
      ready_reg <= 1'b0;
    end else if (done) begin
      ready_reg <= 1'b1;
    end else if (rd_result) begin
      ready_reg <= 1'b0;
    end
  end

  // read mux, sampled in the setup cycle so read data comes from a flop
  always_comb begin
    rd_data = '0;
    if (PADDR_I == CTRL_OFS) begin
      rd_data[CTL_EN_BIT]              = en_reg;
      rd_data[CTL_CONT_BIT]            = cont_reg;
      rd_data[CTL_MODE_HI:CTL_MODE_LO] = mode_reg;
      rd_data[CTL_EXT_BIT]             = ext_reg;
      rd_data[CTL_DIV_HI:CTL_DIV_LO]   = div_reg;
      rd_data[CTL_BYP_N_BIT]           = byp_n_reg;
      rd_data[CTL_BYP_P_BIT]           = byp_p_reg;
      rd_data[CTL_ACQ_HI:CTL_ACQ_LO]   = acq_reg;
    end else if (PADDR_I == CPOS_OFS) begin
      rd_data[SEL_W-1:0] = pos_reg;
    end else if (PADDR_I == CNEG_OFS) begin
      rd_data[SEL_W-1:0] = neg_reg;
    end else if (PADDR_I == STAT_OFS) begin
      rd_data[STA_READY_BIT] = ready_reg;
    end else if (PADDR_I == RSLT_OFS) begin
      rd_data = result_reg;
    end else if (PADDR_I == SRST_OFS) begin
      rd_data = '0;
    end else if (PADDR_I == GAIN_OFS) begin
      rd_data[GAIN_W-1:0] = gain_reg;
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      PRDATA_O <= '0;
    end else if (rd_setup) begin
      PRDATA_O <= rd_data;
    end
  end

  // drive of the analog front end
  assign POSITIVE_CHANNEL_SELECT_O  = pos_reg;
  assign NEGATIVE_CHANNEL_SELECT_O  = neg_reg;
  assign CONV_MODE_O                = mode_reg;
  assign BYPASS_POS_BUFFER_O        = byp_p_reg;
  assign BYPASS_NEG_BUFFER_O        = byp_n_reg;
  assign AMPLIFIER_GAIN_CODE_O      = gain_reg;
  assign AMPLIFIER_IN_PATH_O        = in_path_reg;
  assign CONVERSION_ACTIVE_OUTPUT_O = busy;
  assign RESULT_READY_FLAG_O        = ready_reg;
endmodule
`default_nettype wire

// [test/adcctl_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module adcctl_bench;
  import adcctl_pkg::*;
  localparam logic [31:0] CDEF = 32'h0008_0200;
  localparam logic [1:0]  MD [4] = '{MODE_DIFF, MODE_DIFF, MODE_DIFF, MODE_PSEUDO};
  localparam logic [11:0] RW [4] = '{12'h000, 12'hfff, 12'h801, 12'ha5a};
  localparam logic [31:0] EX [4] = '{32'hf800_0000, 32'h07ff_0000, 32'h0001_0000, 32'h0a5a_0000};
  logic        clk, rst_n, psel, pen, pwr, trig, pready, pslverr, e;
  logic        byp_p, byp_n, in_path, smp, cclk, act, rdy;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [4:0]  pos, neg, gain;
  logic [1:0]  mode;
  logic [11:0] code, cd;
  int          mismatches, n_checks, off, na, ns, nt;
  adcctl_top i_dut (.MCLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .CONV_TRIGGER_I(trig), .CORE_DATA_I(cd),
    .POSITIVE_CHANNEL_SELECT_O(pos), .NEGATIVE_CHANNEL_SELECT_O(neg), .CONV_MODE_O(mode),
    .BYPASS_POS_BUFFER_O(byp_p), .BYPASS_NEG_BUFFER_O(byp_n), .AMPLIFIER_GAIN_CODE_O(gain),
    .AMPLIFIER_IN_PATH_O(in_path), .SAMPLE_O(smp), .CONV_CLK_O(cclk),
    .CONVERSION_ACTIVE_OUTPUT_O(act), .RESULT_READY_FLAG_O(rdy));
  adcctl_core_model i_core (.clk_i(clk), .rst_n_i(rst_n), .active_i(act), .code_i(code),
    .data_o(cd));
  task chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pen    <= 1'b0;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] x, input string m);
    apb(1'b0, a, 32'h0);
    chk(q === x, m);
  endtask
  // clears the flag, starts one conversion and counts phases until ready
  task conv(input logic [31:0] c);
    apb(1'b0, RSLT_OFS, 32'h0);
    apb(1'b1, CTRL_OFS, c | 32'h3);
    na = 0;
    ns = 0;
    nt = 0;
    while (rdy !== 1'b1 && na < 5000) begin
      @(posedge clk);
      na += int'(act === 1'b1);
      ns += int'(smp === 1'b1);
      nt += int'(cclk === 1'b1);
    end
  endtask
  task wait_act(input logic v, input int lim);
    int k;
    k = 0;
    while (act !== v && k < lim) begin
      @(posedge clk);
      k++;
    end
    chk(act === v, "active level");
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #500000;
    mismatches++;
    finish_test();
  end
  initial begin
    {rst_n, psel, pen, pwr, trig, paddr, pwdata, code} = '0;
    mismatches = 0;
    n_checks = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(CTRL_OFS, CDEF, "ctrl reset");
    apb(1'b0, 8'h1c, 32'h0);
    chk(e === 1'b1 && q === 32'h0 && pready === 1'b1, "unmapped");
    code <= 12'hfff;
    conv(CDEF);
    off = na - 54;
    chk(ns == 16 && nt == 27 && off >= 0 && off <= 2, "default timing");
    rd_chk(STAT_OFS, 32'h1, "ready set");
    rd_chk(RSLT_OFS, 32'h0fff_0000, "single full");
    @(posedge clk);
    chk(rdy === 1'b0, "ready clear");
    for (int i = 0; i < 4; i++) begin
      code <= RW[i];
      conv(CDEF | {27'h0, MD[i], 3'h0});
      chk(mode === MD[i], "mode");
      rd_chk(RSLT_OFS, EX[i], "format");
    end
    apb(1'b1, CPOS_OFS, {27'h0, CH_TEMP});
    conv(CDEF);
    chk(ns == 512 && na - 1120 == off, "temp timing");
    apb(1'b1, CPOS_OFS, 32'h0);
    conv(32'h0004_0300);
    chk(ns == 12 && na - 69 == off, "user timing");
    for (int g = 0; g < 32; g++) begin
      apb(1'b1, GAIN_OFS, g);
      @(posedge clk);
      chk(gain === g[4:0], "gain");
    end
    apb(1'b1, CPOS_OFS, {27'h0, CH_PHOTO1});
    apb(1'b1, CNEG_OFS, {27'h0, CHN_PHOTO1});
    apb(1'b1, CTRL_OFS, CDEF | 32'h8000);
    @(posedge clk);
    chk(byp_p === 1'b1 && byp_n === 1'b0 && pos === CH_PHOTO1 && neg === CHN_PHOTO1,
        "bypass pos");
    apb(1'b1, GAIN_OFS, 32'h1f);
    conv(CDEF | 32'h4000 | {27'h0, MODE_PSEUDO, 3'h0});
    chk(byp_p === 1'b0 && byp_n === 1'b1 && in_path === 1'b1, "photo path");
    apb(1'b1, CPOS_OFS, 32'h14);
    rd_chk(CPOS_OFS, {27'h0, CH_PHOTO1}, "over max");
    apb(1'b1, CPOS_OFS, {27'h0, CH_AGND});
    rd_chk(CPOS_OFS, {27'h0, CH_AGND}, "ground select");
    apb(1'b0, RSLT_OFS, 32'h0);
    apb(1'b1, CTRL_OFS, CDEF | 32'h21);
    trig <= 1'b1;
    wait_act(1'b1, 20);
    wait_act(1'b0, 200);
    wait_act(1'b1, 4);
    trig <= 1'b0;
    wait_act(1'b0, 200);
    repeat (100) @(posedge clk);
    chk(act === 1'b0, "no third");
    apb(1'b1, CTRL_OFS, CDEF | 32'h5);
    wait_act(1'b1, 10);
    wait_act(1'b0, 200);
    wait_act(1'b1, 4);
    apb(1'b1, CTRL_OFS, CDEF);
    wait_act(1'b0, 200);
    apb(1'b1, CTRL_OFS, CDEF | 32'h8003);
    apb(1'b1, SRST_OFS, 32'h0);
    @(posedge clk);
    chk(act === 1'b0 && rdy === 1'b0 && byp_p === 1'b0 && gain === 5'h0, "soft reset");
    rd_chk(CTRL_OFS, CDEF, "ctrl default");
    finish_test();
  end
endmodule
bind adcctl_top adcctl_monitor i_mon (.MCLK_I, .RST_N_I, .PSEL_I, .PENABLE_I, .PWRITE_I,
  .PADDR_I, .PWDATA_I, .PRDATA_O, .POSITIVE_CHANNEL_SELECT_O, .NEGATIVE_CHANNEL_SELECT_O,
  .CONV_MODE_O, .BYPASS_POS_BUFFER_O, .BYPASS_NEG_BUFFER_O, .AMPLIFIER_GAIN_CODE_O,
  .AMPLIFIER_IN_PATH_O, .CONVERSION_ACTIVE_OUTPUT_O, .RESULT_READY_FLAG_O);
`default_nettype wire

// [test/adcctl_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module adcctl_core_model
  import adcctl_pkg::*;
(
  input  wire logic                         clk_i,
  input  wire logic                         rst_n_i,
  input  wire logic                         active_i,
  input  wire logic [adcctl_pkg::RES_W-1:0] code_i,
  output logic      [adcctl_pkg::RES_W-1:0] data_o
);
  logic act_d;
  // code valid during conversion and one cycle after, scrambled otherwise
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      act_d  <= 1'b0;
      data_o <= '0;
    end else begin
      act_d  <= active_i;
      data_o <= (active_i || act_d) ? code_i : ~data_o;
    end
  end
endmodule
`default_nettype wire

// [test/adcctl_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module adcctl_monitor
  import adcctl_pkg::*;
(
  input wire logic                          MCLK_I,
  input wire logic                          RST_N_I,
  input wire logic                          PSEL_I,
  input wire logic                          PENABLE_I,
  input wire logic                          PWRITE_I,
  input wire logic [adcctl_pkg::ADDR_W-1:0] PADDR_I,
  input wire logic [adcctl_pkg::DATA_W-1:0] PWDATA_I,
  input wire logic [adcctl_pkg::DATA_W-1:0] PRDATA_O,
  input wire logic [adcctl_pkg::SEL_W-1:0]  POSITIVE_CHANNEL_SELECT_O,
  input wire logic [adcctl_pkg::SEL_W-1:0]  NEGATIVE_CHANNEL_SELECT_O,
  input wire logic [1:0]                    CONV_MODE_O,
  input wire logic                          BYPASS_POS_BUFFER_O,
  input wire logic                          BYPASS_NEG_BUFFER_O,
  input wire logic [adcctl_pkg::GAIN_W-1:0] AMPLIFIER_GAIN_CODE_O,
  input wire logic                          AMPLIFIER_IN_PATH_O,
  input wire logic                          CONVERSION_ACTIVE_OUTPUT_O,
  input wire logic                          RESULT_READY_FLAG_O
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);
  logic wr;
  logic rd;
  logic sr;
  logic ph;
  assign wr = PSEL_I && PENABLE_I && PWRITE_I;
  assign rd = PSEL_I && PENABLE_I && !PWRITE_I;
  assign sr = wr && PADDR_I == SRST_OFS;
  assign ph = POSITIVE_CHANNEL_SELECT_O inside {CH_PHOTO0, CH_PHOTO1} ||
              NEGATIVE_CHANNEL_SELECT_O inside {CHN_PHOTO0, CHN_PHOTO1};
  // conversion end not caused by a soft reset
  sequence s_end;
    $fell(CONVERSION_ACTIVE_OUTPUT_O) && !$past(sr);
  endsequence
  sequence s_rslt_rd;
    rd && PADDR_I == RSLT_OFS;
  endsequence
  chk_bypass_write: assert property (wr && PADDR_I == CTRL_OFS |=>
    BYPASS_POS_BUFFER_O == $past(PWDATA_I[CTL_BYP_P_BIT]) &&
    BYPASS_NEG_BUFFER_O == $past(PWDATA_I[CTL_BYP_N_BIT])) else $error("bypass bits wrong");
  chk_mode_write: assert property (wr && PADDR_I == CTRL_OFS && PWDATA_I[4:3] != 2'h3
    |=> CONV_MODE_O == $past(PWDATA_I[4:3])) else $error("mode field wrong");
  chk_select_apart: assert property (wr && PADDR_I == CPOS_OFS |=> $stable(CONV_MODE_O) &&
    $stable(BYPASS_POS_BUFFER_O) && $stable(BYPASS_NEG_BUFFER_O)) else $error("select moved ctrl");
  chk_pos_write: assert property (wr && PADDR_I == CPOS_OFS && PWDATA_I <= {27'h0, CH_POS_MAX}
    |=> POSITIVE_CHANNEL_SELECT_O == $past(PWDATA_I[4:0])) else $error("positive select wrong");
  chk_gain_write: assert property (wr && PADDR_I == GAIN_OFS
    |=> AMPLIFIER_GAIN_CODE_O == $past(PWDATA_I[4:0])) else $error("gain code wrong");
  chk_amp_path: assert property (ph |-> AMPLIFIER_IN_PATH_O) else $error("amplifier left path");
  chk_ready_after: assert property (s_end |=> RESULT_READY_FLAG_O) else $error("ready not set");
  chk_read_clear: assert property (s_rslt_rd and !$fell(CONVERSION_ACTIVE_OUTPUT_O)
    |=> !RESULT_READY_FLAG_O) else $error("ready not cleared");
  chk_low_zero: assert property (s_rslt_rd |-> PRDATA_O[15:0] == 16'h0) else $error("low half set");
  chk_sign_fill: assert property (s_rslt_rd |-> PRDATA_O[31:28] == {4{PRDATA_O[27]}} ||
    PRDATA_O[31:28] == 4'h0) else $error("upper bits wrong");
  chk_soft_reset: assert property (sr |=> !CONVERSION_ACTIVE_OUTPUT_O && !RESULT_READY_FLAG_O &&
    CONV_MODE_O == MODE_RST && AMPLIFIER_GAIN_CODE_O == GAIN_RST &&
    POSITIVE_CHANNEL_SELECT_O == SEL_RST) else $error("soft reset incomplete");
endmodule
`default_nettype wire
